/* File: oxs_pkg.sv */
// Shared constants and types for the oximeter shared-SRAM controller
`default_nettype none
package oxs_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int SEQ_PERIOD_NS = 16000;
   localparam int SEQ_HALF_INT  = SEQ_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam logic [8:0] SEQ_HALF_CYC = 9'(SEQ_HALF_INT);
   // Host waits this many cycles before trusting the ready line
   localparam logic [1:0] HOST_SETTLE_CYC = 2'h2;

   // ----------------------------------------------------------------
   // Shared RAM and ISA decode
   // ----------------------------------------------------------------
   localparam int RAM_AW    = 15;
   localparam int RAM_WORDS = 32768;
   localparam logic [19:0] ISA_RAM_BASE  = 20'hD0000;
   localparam logic [19:0] ISA_CTRL_ADDR = 20'hD8000;

   // ----------------------------------------------------------------
   // Local processor address map
   // ----------------------------------------------------------------
   localparam logic [15:0] CPU_STB0_ADDR = 16'h8000;
   localparam logic [15:0] CPU_STB1_ADDR = 16'h8001;
   localparam logic [15:0] CPU_STB2_ADDR = 16'h8002;
   localparam logic [15:0] CPU_CMP_ADDR  = 16'h8003;
   localparam logic [15:0] CPU_INTF_ADDR = 16'h8004;

   // ----------------------------------------------------------------
   // Processor-control line select bits (host write data)
   // ----------------------------------------------------------------
   localparam int PCL_RESET = 0;
   localparam int PCL_HALT  = 1;
   localparam int PCL_LOCAL_FAST_IRQ_N  = 2;
   localparam logic [2:0] PCL_RST_VAL = 3'h7;

   // ----------------------------------------------------------------
   // Host controller register map
   // ----------------------------------------------------------------
   localparam logic [7:0] HREG_ADDR   = 8'h00;
   localparam logic [7:0] HREG_WDATA  = 8'h04;
   localparam logic [7:0] HREG_CMD    = 8'h08;
   localparam logic [7:0] HREG_RDATA  = 8'h0C;
   localparam logic [7:0] HREG_STATUS = 8'h10;
   localparam logic [7:0] HREG_IRQ_ST = 8'h14;
   localparam logic [7:0] HREG_IRQ_MK = 8'h18;
   localparam int CMD_GO   = 0;
   localparam int CMD_READ = 1;
   localparam int EV_WR_DONE = 0;
   localparam int EV_RD_DONE = 1;

   // ----------------------------------------------------------------
   // State machines
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      DS_IDLE  = 4'h1,
      DS_WAIT  = 4'h2,
      DS_SERVE = 4'h4,
      DS_DONE  = 4'h8
   } oxs_dev_state_t;

   typedef enum logic [2:0] {
      HS_IDLE   = 3'h1,
      HS_STROBE = 3'h2,
      HS_WAIT   = 3'h4
   } oxs_host_state_t;

endpackage
`default_nettype wire

/* File: oxs_isa_if.sv */
// ISA-side connection between the shared-RAM device and its host
`default_nettype none
interface oxs_isa_if;
   logic [19:0] isa_addr;
   logic [7:0]  isa_wdata;
   logic [7:0]  isa_rdata;
   logic        isa_memr_n;
   logic        isa_memw_n;
   logic        iochrdy;

   // Device end: target of the memory cycles
   modport device (
      input  isa_addr,
      input  isa_wdata,
      input  isa_memr_n,
      input  isa_memw_n,
      output isa_rdata,
      output iochrdy
   );

   // Host end: initiator of the memory cycles
   modport host (
      output isa_addr,
      output isa_wdata,
      output isa_memr_n,
      output isa_memw_n,
      input  isa_rdata,
      input  iochrdy
   );
endinterface
`default_nettype wire

/* File: oxs_dev.sv */
// Digital section: shared SRAM arbiter, control register and sequencer
//
// Strobed register access and the register offsets were chosen for this implementation.
`default_nettype none
module oxs_dev
   import oxs_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   oxs_isa_if.device        isa,
   input  wire logic [15:0] cpu_addr,
   input  wire logic [7:0]  cpu_wdata,
   input  wire logic        cpu_we,
   input  wire logic        cpu_re,
   output logic      [7:0]  cpu_rdata,
   input  wire logic        comparator_out_n,
   input  wire logic        interference_n,
   output logic             tristate_control,
   output logic             local_cpu_reset_n,
   output logic             local_cpu_halt_n,
   output logic             local_fast_irq_n,
   output logic             ctrl_strobe_0,
   output logic             ctrl_strobe_1,
   output logic             ctrl_strobe_2,
   output logic             diagnostic_source,
   output logic             run_calibrate_mode,
   output logic      [1:0]  ir_gain,
   output logic      [1:0]  red_gain,
   output logic             sample_hold,
   output logic             channel_select,
   output logic      [11:0] dac_code,
   output logic      [1:0]  ac_gain,
   output logic      [1:0]  dc_gain,
   output logic             sequencer_clock,
   output logic             red_led_drive,
   output logic             ir_led_drive,
   output logic      [1:0]  preamp_gain
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Host address falls inside the shared RAM window
   function automatic logic isa_ram_hit(input logic [19:0] a);
      isa_ram_hit = (a[19:RAM_AW] == ISA_RAM_BASE[19:RAM_AW]);
   endfunction

   // Local address matches one fixed location
   function automatic logic cpu_at(input logic [15:0] a,
                                   input logic [15:0] loc);
      cpu_at = (a == loc);
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0]      ram_mem [0:RAM_WORDS-1];
   oxs_dev_state_t  state_reg;
   logic            cpu_ram_use;
   logic            isa_req;
   logic            isa_is_write;
   logic            isa_ctrl_hit;
   logic            isa_ram_go;
   logic [2:0]      pcl_reg;
   logic [7:0]      isa_rdata_reg;
   logic            iochrdy_reg;
   logic [8:0]      seq_div_reg;
   logic [7:0]      seq_step_reg;
   logic            seq_fall;
   logic            seq_rise;
   logic            red_phase;
   logic            ir_phase;

   // ----------------------------------------------------------------
   // Request qualification
   // ----------------------------------------------------------------
   // Local processor owns the RAM in any cycle it touches it
   assign cpu_ram_use  = (cpu_we | cpu_re) & ~cpu_addr[15];
   assign isa_req      = ~isa.isa_memr_n | ~isa.isa_memw_n;
   assign isa_is_write = ~isa.isa_memw_n;
   assign isa_ctrl_hit = (isa.isa_addr == ISA_CTRL_ADDR);
   // Host touches RAM only in SERVE and only when the CPU is not using RAM
   assign isa_ram_go   = (state_reg == DS_SERVE) & ~isa_ctrl_hit
                         & ~cpu_ram_use;

   // ----------------------------------------------------------------
   // Host cycle state machine
   // ----------------------------------------------------------------
   // Host cycles are re-timed here; ready drops on the first edge
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         state_reg <= DS_IDLE;
      end
      else
      begin
         unique case (state_reg)
            DS_IDLE:
               if (isa_req && (isa_ram_hit(isa.isa_addr) || isa_ctrl_hit))
                  state_reg <= DS_WAIT;
            DS_WAIT:
               // Pending cycle stretched while the CPU uses RAM
               if (isa_ctrl_hit || !cpu_ram_use)
                  state_reg <= DS_SERVE;
            DS_SERVE:
               if (isa_ctrl_hit || !cpu_ram_use)
                  state_reg <= DS_DONE;
            DS_DONE:
               if (!isa_req)
                  state_reg <= DS_IDLE;
            default:
               state_reg <= DS_IDLE;
         endcase
      end
   end

   // Ready low from first sight of the cycle until data is aligned
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         iochrdy_reg <= 1'b1;
      else if (state_reg == DS_IDLE && isa_req
               && (isa_ram_hit(isa.isa_addr) || isa_ctrl_hit))
         iochrdy_reg <= 1'b0;
      else if (state_reg == DS_SERVE
               && (isa_ctrl_hit || !cpu_ram_use))
         iochrdy_reg <= 1'b1;
   end

   // Local buffers float for the first SERVE cycle of a RAM access, even if the CPU takes the RAM then
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         tristate_control <= 1'b0;
      else
         tristate_control <= (state_reg == DS_WAIT) && !isa_ctrl_hit
                             && !cpu_ram_use;
   end

   assign isa.iochrdy   = iochrdy_reg;
   assign isa.isa_rdata = isa_rdata_reg;

   // ----------------------------------------------------------------
   // Shared RAM
   // ----------------------------------------------------------------
   // No reset on the array; a single write port, CPU first
   always_ff @(posedge core_clk)
   begin
      if (cpu_we && !cpu_addr[15])
         ram_mem[cpu_addr[RAM_AW-1:0]] <= cpu_wdata;
      else if (isa_ram_go && isa_is_write)
         ram_mem[isa.isa_addr[RAM_AW-1:0]] <= isa.isa_wdata;
   end

   // Host read data; control address reads back the line states
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         isa_rdata_reg <= 8'h00;
      else if (isa_ram_go && !isa_is_write)
         isa_rdata_reg <= ram_mem[isa.isa_addr[RAM_AW-1:0]];
      else if (state_reg == DS_SERVE && isa_ctrl_hit && !isa_is_write)
         isa_rdata_reg <= {5'h00, pcl_reg};
   end

   // Local read data, valid the cycle after the read strobe
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         cpu_rdata <= 8'h00;
      else if (cpu_re && !cpu_addr[15])
         cpu_rdata <= ram_mem[cpu_addr[RAM_AW-1:0]];
      else if (cpu_re && cpu_at(cpu_addr, CPU_CMP_ADDR))
         cpu_rdata <= {7'h00, comparator_out_n};
      else if (cpu_re && cpu_at(cpu_addr, CPU_INTF_ADDR))
         cpu_rdata <= {7'h00, interference_n};
      else if (cpu_re)
         cpu_rdata <= 8'h00;
   end

   // ----------------------------------------------------------------
   // Processor-control lines
   // ----------------------------------------------------------------
   // Each line is active low; write data picks which to assert
   for (genvar i = 0; i < 3; i++)
   begin : g_pcl
      always_ff @(posedge core_clk)
      begin
         if (!nrst)
            pcl_reg[i] <= PCL_RST_VAL[i];
         else if (state_reg == DS_SERVE && isa_ctrl_hit)
         begin
            if (isa_is_write && isa.isa_wdata[i])
               pcl_reg[i] <= 1'b0;
            else if (!isa_is_write)
               pcl_reg[i] <= 1'b1;
         end
         // Otherwise the line simply holds
      end
   end

   assign local_cpu_reset_n = pcl_reg[PCL_RESET];
   assign local_cpu_halt_n  = pcl_reg[PCL_HALT];
   assign local_fast_irq_n  = pcl_reg[PCL_LOCAL_FAST_IRQ_N];

   // ----------------------------------------------------------------
   // Control register strobes and latches
   // ----------------------------------------------------------------
   // One-cycle strobes decoded from local writes
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         ctrl_strobe_0 <= 1'b0;
         ctrl_strobe_1 <= 1'b0;
         ctrl_strobe_2 <= 1'b0;
      end
      else
      begin
         ctrl_strobe_0 <= cpu_we && cpu_at(cpu_addr, CPU_STB0_ADDR);
         ctrl_strobe_1 <= cpu_we && cpu_at(cpu_addr, CPU_STB1_ADDR);
         ctrl_strobe_2 <= cpu_we && cpu_at(cpu_addr, CPU_STB2_ADDR);
      end
   end

   // Byte 0: modes, preamp gains, sample-hold, channel
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         diagnostic_source  <= 1'b0;
         run_calibrate_mode <= 1'b0;
         ir_gain            <= 2'h0;
         red_gain           <= 2'h0;
         sample_hold        <= 1'b0;
         channel_select     <= 1'b0;
      end
      else if (cpu_we && cpu_at(cpu_addr, CPU_STB0_ADDR))
      begin
         diagnostic_source  <= cpu_wdata[0];
         run_calibrate_mode <= cpu_wdata[1];
         ir_gain            <= cpu_wdata[3:2];
         red_gain           <= cpu_wdata[5:4];
         sample_hold        <= cpu_wdata[6];
         channel_select     <= cpu_wdata[7];
      end
   end

   // Bytes 1 and 2: DAC code and the two gain fields
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         dac_code <= 12'h000;
         ac_gain  <= 2'h0;
         dc_gain  <= 2'h0;
      end
      else if (cpu_we && cpu_at(cpu_addr, CPU_STB1_ADDR))
         dac_code[7:0] <= cpu_wdata;
      else if (cpu_we && cpu_at(cpu_addr, CPU_STB2_ADDR))
      begin
         dac_code[11:8] <= cpu_wdata[3:0];
         ac_gain        <= cpu_wdata[5:4];
         dc_gain        <= cpu_wdata[7:6];
      end
   end

   // ----------------------------------------------------------------
   // Sequencer clock and LED program
   // ----------------------------------------------------------------
   // Free-running divider; never gated, so the sequencer keeps time
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         seq_div_reg     <= 9'h000;
         sequencer_clock <= 1'b0;
      end
      else if (seq_div_reg == SEQ_HALF_CYC - 9'h001)
      begin
         seq_div_reg     <= 9'h000;
         sequencer_clock <= ~sequencer_clock;
      end
      else
         seq_div_reg <= seq_div_reg + 9'h001;
   end

   assign seq_fall  = (seq_div_reg == SEQ_HALF_CYC - 9'h001)
                      & sequencer_clock;
   assign seq_rise  = (seq_div_reg == SEQ_HALF_CYC - 9'h001)
                      & ~sequencer_clock;
   // Quarter cycles: red, dark, infrared, dark
   assign red_phase = (seq_step_reg[7:6] == 2'h0) & run_calibrate_mode;
   assign ir_phase  = (seq_step_reg[7:6] == 2'h2) & run_calibrate_mode;

   // Step counter advances on the falling sequencer edge
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         seq_step_reg <= 8'h00;
      else if (seq_fall)
         seq_step_reg <= seq_step_reg + 8'h01;
   end

   // Drives and gain switch together on the rising edge
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         red_led_drive <= 1'b0;
         ir_led_drive  <= 1'b0;
         preamp_gain   <= 2'h0;
      end
      else if (seq_rise)
      begin
         red_led_drive <= red_phase;
         ir_led_drive  <= ir_phase;
         preamp_gain   <= red_phase ? red_gain : ir_gain;
      end
   end

endmodule
`default_nettype wire

/* File: oxs_host.sv */
// ISA host end: register-driven initiator of shared-RAM cycles
`default_nettype none
module oxs_host
   import oxs_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   oxs_isa_if.host          isa,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             irq
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   oxs_host_state_t state_reg;
   logic [19:0]     addr_reg;
   logic [7:0]      wdata_reg;
   logic [7:0]      rdata_reg;
   logic            read_reg;
   logic [1:0]      settle_reg;
   logic [1:0]      irq_st_reg;
   logic [1:0]      irq_mk_reg;
   logic [1:0]      ev_set;
   logic            go;
   logic            finish;

   assign go     = reg_wr && (reg_addr == HREG_CMD) && reg_wdata[CMD_GO]
                   && (state_reg == HS_IDLE);
   // Extended cycles are tolerated: we simply wait for ready
   assign finish = (state_reg == HS_WAIT) && (settle_reg == 2'h0)
                   && isa.iochrdy;
   assign ev_set = finish ? (read_reg ? 2'h2 : 2'h1) : 2'h0;

   // ----------------------------------------------------------------
   // Set-up registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         addr_reg  <= 20'h00000;
         wdata_reg <= 8'h00;
      end
      else
      begin
         if (reg_wr && reg_addr == HREG_ADDR)
            addr_reg <= reg_wdata[19:0];
         if (reg_wr && reg_addr == HREG_WDATA)
            wdata_reg <= reg_wdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Cycle state machine
   // ----------------------------------------------------------------
   // Ignores a start while busy; the device must see ready drop first
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         state_reg  <= HS_IDLE;
         read_reg   <= 1'b0;
         settle_reg <= 2'h0;
         rdata_reg  <= 8'h00;
      end
      else
      begin
         unique case (state_reg)
            HS_IDLE:
               if (go)
               begin
                  state_reg  <= HS_STROBE;
                  read_reg   <= reg_wdata[CMD_READ];
                  settle_reg <= HOST_SETTLE_CYC;
               end
            HS_STROBE:
               state_reg <= HS_WAIT;
            HS_WAIT:
               if (settle_reg != 2'h0)
                  settle_reg <= settle_reg - 2'h1;
               else if (isa.iochrdy)
               begin
                  state_reg <= HS_IDLE;
                  if (read_reg)
                     rdata_reg <= isa.isa_rdata;
               end
            default:
               state_reg <= HS_IDLE;
         endcase
      end
   end

   // Bus pins come from flops; strobes live through STROBE and WAIT
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         isa.isa_addr   <= 20'h00000;
         isa.isa_wdata  <= 8'h00;
         isa.isa_memr_n <= 1'b1;
         isa.isa_memw_n <= 1'b1;
      end
      else if (go)
      begin
         isa.isa_addr   <= addr_reg;
         isa.isa_wdata  <= wdata_reg;
         isa.isa_memr_n <= ~reg_wdata[CMD_READ];
         isa.isa_memw_n <= reg_wdata[CMD_READ];
      end
      else if (finish)
      begin
         isa.isa_memr_n <= 1'b1;
         isa.isa_memw_n <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   // Write one to clear; a new event in the same cycle wins
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         irq_st_reg <= 2'h0;
         irq_mk_reg <= 2'h0;
         irq        <= 1'b0;
      end
      else
      begin
         if (reg_wr && reg_addr == HREG_IRQ_ST)
            irq_st_reg <= (irq_st_reg & ~reg_wdata[1:0]) | ev_set;
         else
            irq_st_reg <= irq_st_reg | ev_set;
         if (reg_wr && reg_addr == HREG_IRQ_MK)
            irq_mk_reg <= reg_wdata[1:0];
         irq <= |(irq_st_reg & irq_mk_reg);
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         reg_rdata <= 32'h00000000;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            HREG_ADDR:   reg_rdata <= {12'h000, addr_reg};
            HREG_WDATA:  reg_rdata <= {24'h000000, wdata_reg};
            HREG_CMD:    reg_rdata <= {30'h00000000, read_reg, 1'b0};
            HREG_RDATA:  reg_rdata <= {24'h000000, rdata_reg};
            HREG_STATUS: reg_rdata <= {31'h00000000,
                                       state_reg != HS_IDLE};
            HREG_IRQ_ST: reg_rdata <= {30'h00000000, irq_st_reg};
            HREG_IRQ_MK: reg_rdata <= {30'h00000000, irq_mk_reg};
            default:     reg_rdata <= 32'h00000000;
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: oxs_isa_properties.sv */
// Assertions watching the ISA link between host and device ends
`default_nettype none
module oxs_isa_properties
   import oxs_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic [19:0] isa_addr,
   input wire logic [7:0]  isa_wdata,
   input wire logic [7:0]  isa_rdata,
   input wire logic        isa_memr_n,
   input wire logic        isa_memw_n,
   input wire logic        iochrdy
);
   // ----------------------------------------------------------------
   // Decode and properties
   // ----------------------------------------------------------------
   logic hit;
   logic act;
   assign hit = (isa_addr[19:15] == ISA_RAM_BASE[19:15])
              | (isa_addr == ISA_CTRL_ADDR);
   assign act = !(isa_memr_n && isa_memw_n);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // A fresh cycle only after a release, so the device is idle
   sequence s_start;
      $rose(act) && hit;
   endsequence
   sequence s_hold;
      !iochrdy [*2];
   endsequence
   a_ready_drops: assert property (s_start |=> s_hold)
      else $error("ready not held after valid cycle");
   a_miss_ignored: assert property (act && !hit |-> iochrdy)
      else $error("ready dropped outside window");
   a_idle_ready: assert property (!act |-> iochrdy)
      else $error("ready low with no cycle");
   a_host_holds: assert property (act && !iochrdy |=>
      act && $stable(isa_addr))
      else $error("host let go while held");
   a_one_strobe: assert property (isa_memr_n || isa_memw_n)
      else $error("both strobes low");
   a_release_soon: assert property ($rose(iochrdy) |->
      ##[0:6] !act)
      else $error("host kept strobe after ready");
   a_rdata_kept: assert property (isa_memr_n |=>
      $stable(isa_rdata))
      else $error("read data moved outside read");
   a_ctrl_short: assert property ($rose(act)
      && isa_addr == ISA_CTRL_ADDR |-> ##[1:8] iochrdy)
      else $error("control access never ready");
endmodule
`default_nettype wire

/* File: test_oximeter_shared_sram_ctrl.sv */
// Bench joining host and device ends, driving both user sides
`default_nettype none
module test_oximeter_shared_sram_ctrl
   import oxs_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Signals, instances and access tasks
   // ----------------------------------------------------------------
   logic core_clk, nrst, cpu_we, cpu_re, reg_wr, reg_rd, cmp_n, intf_n;
   logic [15:0] cpu_addr;
   logic [7:0] cpu_wdata, cpu_rdata, reg_addr;
   logic [31:0] reg_wdata, reg_rdata, q;
   logic irq, flt, rst_n, halt_n, local_fast_irq_n_n, s0, s1, s2, dsrc, rcal, sh, chs;
   logic sclk, sprev, red, ir, ts_seen, red_seen, ir_seen;
   logic [1:0] irg, rdg, acg, dcg, pg;
   logic [11:0] dac;
   int bad_count, n_compared, cyc, rises;
   oxs_isa_if isa ();
   oxs_dev i_oxs_dev (.core_clk(core_clk), .nrst(nrst), .isa(isa),
      .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_we(cpu_we),
      .cpu_re(cpu_re), .cpu_rdata(cpu_rdata), .comparator_out_n(cmp_n),
      .interference_n(intf_n), .tristate_control(flt),
      .local_cpu_reset_n(rst_n), .local_cpu_halt_n(halt_n),
      .local_fast_irq_n(local_fast_irq_n_n), .ctrl_strobe_0(s0), .ctrl_strobe_1(s1),
      .ctrl_strobe_2(s2), .diagnostic_source(dsrc),
      .run_calibrate_mode(rcal), .ir_gain(irg), .red_gain(rdg),
      .sample_hold(sh), .channel_select(chs), .dac_code(dac),
      .ac_gain(acg), .dc_gain(dcg), .sequencer_clock(sclk),
      .red_led_drive(red), .ir_led_drive(ir), .preamp_gain(pg));
   oxs_host i_oxs_host (.core_clk(core_clk), .nrst(nrst), .isa(isa),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   oxs_isa_properties i_oxs_isa_properties (.core_clk(core_clk),
      .nrst(nrst), .isa_addr(isa.isa_addr), .isa_wdata(isa.isa_wdata),
      .isa_rdata(isa.isa_rdata), .isa_memr_n(isa.isa_memr_n),
      .isa_memw_n(isa.isa_memw_n), .iochrdy(isa.iochrdy));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task conclude;
      if (bad_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // One-cycle strobe, data read back in the following cycle
   task automatic hx(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      if (w) reg_wr <= 1'b1; else reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   task automatic cx(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      cpu_addr <= a;
      cpu_wdata <= d;
      if (w) cpu_we <= 1'b1; else cpu_re <= 1'b1;
      @(posedge core_clk);
      cpu_we <= 1'b0;
      cpu_re <= 1'b0;
      #1 q = {24'h0, cpu_rdata};
   endtask
   // Bounded poll: a stuck busy gives up after 200 status reads, well before the cycle ceiling
   task automatic isa_op(input logic rd, input logic [19:0] a,
                         input logic [7:0] d);
      hx(1, HREG_ADDR, {12'h0, a});
      hx(1, HREG_WDATA, {24'h0, d});
      hx(1, HREG_CMD, {30'h0, rd, 1'b1});
      q = 32'h1;
      for (int k = 0; k < 200 && q[0] !== 1'b0; k++) hx(0, HREG_STATUS, 0);
      hx(0, HREG_RDATA, 0);
   endtask
   // ----------------------------------------------------------------
   // Clock, monitors and tests
   // ----------------------------------------------------------------
   initial
   begin
      core_clk = 0;
      forever #25 core_clk = ~core_clk;
   end
   // Sequencer phase checks and the run ceiling
   always @(negedge core_clk)
   begin
      cyc++;
      red_seen |= red;
      ir_seen |= ir;
      ts_seen |= flt;
      if (sclk && !sprev) rises++;
      sprev = sclk;
      if (red || ir)
         chk({red, ir, pg}, {red, !red, red ? rdg : irg});
      if (cyc == 60000)
      begin
         bad_count++;
         conclude();
      end
   end
   initial
   begin
      {nrst, cpu_we, cpu_re, reg_wr, reg_rd, sprev} = 0;
      {ts_seen, red_seen, ir_seen, cmp_n, intf_n} = 5'h03;
      {cpu_addr, cpu_wdata, reg_addr, reg_wdata} = 0;
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      chk({local_fast_irq_n_n, halt_n, rst_n}, 3'h7);
      isa_op(0, 20'hD0010, 8'hA5);
      cx(0, 16'h0010, 0);
      chk(q, 8'hA5);
      cx(1, 16'h7FFF, 8'h3C);
      isa_op(1, 20'hD7FFF, 0);
      chk(q, 8'h3C);
      chk(ts_seen, 1);
      chk(irq, 0);
      hx(0, HREG_IRQ_ST, 0);
      chk(q, 3);
      hx(1, HREG_IRQ_MK, 1);
      @(posedge core_clk);
      #1 chk(irq, 1);
      hx(1, HREG_IRQ_ST, 1);
      @(posedge core_clk);
      #1 chk(irq, 0);
      // Local side reads RAM every cycle while the host waits
      cx(1, 16'h0100, 8'h96);
      fork
         begin
            @(posedge core_clk);
            cpu_re <= 1'b1;
            repeat (30) @(posedge core_clk);
            #1 chk(isa.iochrdy, 0);
            chk(flt, 0);
            @(posedge core_clk);
            cpu_re <= 1'b0;
         end
         isa_op(1, 20'hD0100, 0);
      join
      chk(q, 8'h96);
      isa_op(0, ISA_CTRL_ADDR, 8'h05);
      chk({local_fast_irq_n_n, halt_n, rst_n}, 3'h2);
      isa_op(0, 20'hD0000, 8'h07);
      chk({local_fast_irq_n_n, halt_n, rst_n}, 3'h2);
      isa_op(0, ISA_CTRL_ADDR, 8'h02);
      chk({local_fast_irq_n_n, halt_n, rst_n}, 3'h0);
      isa_op(1, ISA_CTRL_ADDR, 0);
      chk({local_fast_irq_n_n, halt_n, rst_n}, 3'h7);
      chk(q, 0);
      isa_op(0, 20'hC0000, 8'h11);
      cx(0, 16'h0000, 0);
      chk(q, 8'h07);
      cx(1, CPU_STB0_ADDR, 8'hA7);
      chk({s2, s1, s0, chs, sh, rdg, irg, rcal, dsrc}, 11'h1A7);
      cx(1, CPU_STB1_ADDR, 8'h5A);
      chk({s2, s1, s0}, 3'h2);
      cx(1, CPU_STB2_ADDR, 8'hE3);
      chk({s2, s1, s0, dcg, acg, dac}, {3'h4, 16'hE35A});
      @(posedge core_clk);
      #1 chk({s2, s1, s0}, 3'h0);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge core_clk);
         cmp_n <= i[0];
         intf_n <= i[1];
         cx(0, CPU_CMP_ADDR, 0);
         chk(q, i % 2);
         cx(0, CPU_INTF_ADDR, 0);
         chk(q, i / 2);
      end
      cx(0, 16'h8005, 0);
      chk(q, 0);
      repeat (43000) @(posedge core_clk);
      chk({red_seen, ir_seen}, 2'h3);
      chk(rises > 120, 1);
      conclude();
   end
endmodule
`default_nettype wire
